// File: pkg/cmp_timer_pkg.sv
// constants for the three-instance 8-bit compare timer
// assumes a byte-wide cpu memory bus and one 100 MHz peripheral clock
package cmp_timer_pkg;

	localparam int NUM_INST = 3;
	localparam int NUM_PINS = 2;   // only the first two instances drive a pin
	localparam int CARRIER_INST = 1;

	// register addresses, one per instance except the single CARRIER_ADDR, element 0 is the first instance
	localparam logic [2:0][15:0] SEC_CMP_ADDR  = {16'hFF1B, 16'hFF1A, 16'hFF19};
	localparam logic [2:0][15:0] PRI_CMP_ADDR  = {16'hFF1E, 16'hFF1D, 16'hFF1C};
	localparam logic [2:0][15:0] MODE_ADDR     = {16'hFF6D, 16'hFF6C, 16'hFF69};
	localparam logic [2:0][15:0] COUNT_ADDR    = {16'hFF72, 16'hFF71, 16'hFF70};
	localparam logic [15:0]      CARRIER_ADDR  = 16'hFF6E;

	// reset values and the value read from unmapped addresses
	localparam logic [7:0] CMP_RESET     = 8'h00;
	localparam logic [7:0] MODE_RESET    = 8'h00;
	localparam logic [7:0] CARRIER_RESET = 8'h00;
	localparam logic [7:0] READ_ZERO     = 8'h00;

	// timer_mode_control fields
	localparam int RUN_BIT    = 7;
	localparam int CKS_HI     = 6;
	localparam int CKS_LO     = 4;
	localparam int OPSEL_HI   = 3;
	localparam int OPSEL_LO   = 2;
	localparam int LEVEL_BIT  = 1;
	localparam int GATE_BIT   = 0;

	// carrier_control: bit 0 lets the second instance drive the carrier output
	localparam int CARRIER_EN_BIT = 0;

	typedef enum logic [1:0]
	{
		OP_INTERVAL = 2'b00,
		OP_CARRIER  = 2'b01,
		OP_PWM      = 2'b10,
		OP_BANNED   = 2'b11
	} op_mode_t;

	// count clock taps: divide by 1, 2, 4, 64, 1024 of the peripheral clock
	localparam int NUM_TAPS  = 5;
	localparam int DIV_WIDTH = 10;
	localparam logic [NUM_TAPS-1:0][3:0] TAP_SHIFT = {4'hA, 4'h6, 4'h2, 4'h1, 4'h0};

endpackage : cmp_timer_pkg

// File: verilog/count_prescaler.sv
// prescaler producing one-cycle count enables at each divided rate
// assumes a single free-running clock; enables are registered
module count_prescaler
	import cmp_timer_pkg::*;
#(
	parameter int TAPS  = NUM_TAPS,
	parameter int WIDTH = DIV_WIDTH
)
(
	// clock and reset
	input  wire logic            clk,
	input  wire logic            rst_n,
	// count enables, bit k pulses every 2**TAP_SHIFT[k] cycles
	output logic [TAPS-1:0]      tick
);

	typedef struct packed
	{
		logic [WIDTH-1:0] div;
		logic [TAPS-1:0]  tick;
	} pre_state_t;

	pre_state_t s_q;
	pre_state_t s_d;

	always_comb
	begin
		s_d     = s_q;
		s_d.div = s_q.div + 1'b1;
		for (int k = 0; k < TAPS; k++)
		begin
			// a tap fires when all bits below its shift are zero
			s_d.tick[k] = ((s_q.div & ((WIDTH'(1) << TAP_SHIFT[k]) - WIDTH'(1))) == '0);
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	assign tick = s_q.tick;

endmodule : count_prescaler

// File: verilog/cmp_timer.sv
// three 8-bit compare timers behind a byte-wide cpu memory bus
// assumes bus strobes synchronous to clk, one access per cycle at most
//
// How it works
// - primary match raises irq, inverts output, always
// - primary compare loads only while counting stopped
// - both compares 8-bit, byte read/write, reset zero
// - pwm secondary match inverts output, no irq
// - carrier secondary match raises irq, clears counter
// - running secondary write buffered until old match
// - secondary write colliding with match keeps old
// - secondary compare ignored in interval mode
// - third instance has no pin, irq only
// - carrier mode and register on second instance only
// - all interval; square/pwm only where pin exists
// - run clear stops and zeroes; set counts next
// - mode field 00 interval, 01 carrier, 10 pwm
// - level bit sets idle output, gate bit gates
module cmp_timer
	import cmp_timer_pkg::*;
(
	// clock and reset
	input  wire logic                clk,
	input  wire logic                rst_n,
	// cpu memory bus, byte wide
	input  wire logic [15:0]         bus_addr,
	input  wire logic [7:0]          bus_wdata,
	input  wire logic                bus_wr,
	input  wire logic                bus_rd,
	output logic [7:0]               bus_rdata,
	// to the interrupt controller
	output logic [NUM_INST-1:0]      match_irq,
	// timer output pins and remote-control carrier output
	output logic [NUM_PINS-1:0]      timer_out_pin,
	output logic                     carrier_out
);

	typedef struct packed
	{
		logic [NUM_INST-1:0][7:0] pri_cmp;
		logic [NUM_INST-1:0][7:0] sec_act;
		logic [NUM_INST-1:0][7:0] sec_buf;
		logic [NUM_INST-1:0]      sec_pend;
		logic [NUM_INST-1:0][7:0] mode;
		logic [NUM_INST-1:0][7:0] count;
		logic [NUM_INST-1:0]      out_ff;
		logic [NUM_INST-1:0]      irq;
		logic [NUM_PINS-1:0]      pin;
		logic [7:0]               carrier_ctl;
		logic                     carrier;
		logic [7:0]               rdata;
	} tmr_state_t;

	tmr_state_t           s_q;
	tmr_state_t           s_d;
	logic [NUM_TAPS-1:0]  tick;

	count_prescaler #(
		.TAPS  (NUM_TAPS),
		.WIDTH (DIV_WIDTH)
	) u_prescaler (
		.clk   (clk),
		.rst_n (rst_n),
		.tick  (tick)
	);

	always_comb
	begin
		logic                 run;
		logic                 step;
		logic [2:0]           cks;
		op_mode_t             op;
		logic                 pwm_ok;
		logic                 car_ok;
		logic                 hit0;
		logic                 hit1;
		logic                 wr_sec;
		run    = 1'b0;
		step   = 1'b0;
		cks    = 3'h0;
		op     = OP_INTERVAL;
		pwm_ok = 1'b0;
		car_ok = 1'b0;
		hit0   = 1'b0;
		hit1   = 1'b0;
		wr_sec = 1'b0;
		s_d    = s_q;

		for (int i = 0; i < NUM_INST; i++)
		begin
			run  = s_q.mode[i][RUN_BIT];
			cks  = s_q.mode[i][CKS_HI:CKS_LO];
			op   = op_mode_t'(s_q.mode[i][OPSEL_HI:OPSEL_LO]);
			// unused divider codes give no count clock at all
			step = run && (int'(cks) < NUM_TAPS) && tick[cks];
			// pwm needs a pin; carrier exists on one instance; else interval
			pwm_ok = (op == OP_PWM) && (i < NUM_PINS);
			car_ok = (op == OP_CARRIER) && (i == CARRIER_INST);
			hit0   = step && (s_q.count[i] == s_q.pri_cmp[i]);
			hit1   = step && (pwm_ok || car_ok)
				&& (s_q.count[i] == s_q.sec_act[i]);
			wr_sec = bus_wr && (bus_addr == SEC_CMP_ADDR[i]);

			s_d.irq[i] = hit0 || (car_ok && hit1);

			if (!run)
			begin
				s_d.count[i]  = 8'h00;
				s_d.out_ff[i] = s_q.mode[i][LEVEL_BIT];
			end
			else if (step)
			begin
				if (hit0 || (car_ok && hit1))
					s_d.count[i] = 8'h00;
				else
					s_d.count[i] = s_q.count[i] + 8'h01;
				if (hit0 || (pwm_ok && hit1))
					s_d.out_ff[i] = ~s_q.out_ff[i];
			end

			// buffered value goes live on a match with the old value
			if (hit1 && s_q.sec_pend[i] && !wr_sec)
			begin
				s_d.sec_act[i]  = s_q.sec_buf[i];
				s_d.sec_pend[i] = 1'b0;
			end

			if (wr_sec)
			begin
				s_d.sec_buf[i] = bus_wdata;
				if (!run)
				begin
					// a stopped write is live at once; this is why restart needs it
					s_d.sec_act[i]  = bus_wdata;
					s_d.sec_pend[i] = 1'b0;
				end
				else
					s_d.sec_pend[i] = 1'b1;
			end

			// a running write is dropped, so changing the value is refused
			if (bus_wr && (bus_addr == PRI_CMP_ADDR[i]) && !run)
				s_d.pri_cmp[i] = bus_wdata;

			if (bus_wr && (bus_addr == MODE_ADDR[i]))
			begin
				// other fields are frozen while counting
				if (!run)
					s_d.mode[i] = bus_wdata;
				else
					s_d.mode[i][RUN_BIT] = bus_wdata[RUN_BIT];
			end

			if (i < NUM_PINS)
			begin
				if (s_q.mode[i][GATE_BIT])
					s_d.pin[i] = s_d.out_ff[i];
				else
					s_d.pin[i] = s_q.mode[i][LEVEL_BIT];
			end
		end

		if (bus_wr && (bus_addr == CARRIER_ADDR))
			s_d.carrier_ctl = bus_wdata;
		s_d.carrier = s_d.out_ff[CARRIER_INST] && s_q.carrier_ctl[CARRIER_EN_BIT]
			&& (s_q.mode[CARRIER_INST][OPSEL_HI:OPSEL_LO] == OP_CARRIER);

		if (bus_rd)
		begin
			s_d.rdata = READ_ZERO;
			for (int i = 0; i < NUM_INST; i++)
			begin
				if (bus_addr == PRI_CMP_ADDR[i])
					s_d.rdata = s_q.pri_cmp[i];
				if (bus_addr == SEC_CMP_ADDR[i])
					s_d.rdata = s_q.sec_buf[i];
				if (bus_addr == MODE_ADDR[i])
					s_d.rdata = s_q.mode[i];
				if (bus_addr == COUNT_ADDR[i])
					s_d.rdata = s_q.count[i];
			end
			if (bus_addr == CARRIER_ADDR)
				s_d.rdata = s_q.carrier_ctl;
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s_q             <= '0;
			s_q.pri_cmp     <= {NUM_INST{CMP_RESET}};
			s_q.sec_act     <= {NUM_INST{CMP_RESET}};
			s_q.sec_buf     <= {NUM_INST{CMP_RESET}};
			s_q.mode        <= {NUM_INST{MODE_RESET}};
			s_q.carrier_ctl <= CARRIER_RESET;
		end
		else
			s_q <= s_d;
	end

	assign bus_rdata     = s_q.rdata;
	assign match_irq     = s_q.irq;
	assign timer_out_pin = s_q.pin;   // third instance has no pin
	assign carrier_out   = s_q.carrier;

endmodule : cmp_timer

// File: testbench/cmp_timer_assertions.sv
// port checks for cmp_timer, bound below
// assumes one clock; a shadow of the first mode register follows bus writes
module cmp_timer_chk
	import cmp_timer_pkg::*;
(
	// clock and reset
	input	wire logic			clk,
	input	wire logic			rst_n,
	// bus
	input	wire logic [15:0]		bus_addr,
	input	wire logic [7:0]		bus_wdata,
	input	wire logic			bus_wr,
	input	wire logic			bus_rd,
	input	wire logic [7:0]		bus_rdata,
	// far side
	input	wire logic [NUM_INST-1:0]	match_irq,
	input	wire logic [NUM_PINS-1:0]	timer_out_pin,
	input	wire logic			carrier_out
);
	logic [7:0]	m0_q;
	logic [7:0]	m0_d;
	always_comb
	begin
		m0_d = m0_q;
		// while running only the run bit can move
		if (bus_wr && bus_addr == MODE_ADDR[0])
			m0_d = m0_q[RUN_BIT] ? {bus_wdata[7], m0_q[6:0]} : bus_wdata;
	end
	always_ff @(posedge clk or negedge rst_n)
		if (!rst_n)
			m0_q <= MODE_RESET;
		else
			m0_q <= m0_d;
	default clocking @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	quiet_reset_a: assert property ($rose(rst_n) |->
		!match_irq && !timer_out_pin && !carrier_out && !bus_rdata) else $error("busy after reset");
	unmapped_rd_a: assert property (bus_rd && bus_addr == 16'h0000 |=> !bus_rdata)
		else $error("unmapped read not zero");
	rdata_hold_a: assert property (!bus_rd |=> $stable(bus_rdata))
		else $error("read data moved");
	sec_readback_a: assert property ((bus_wr && bus_addr == SEC_CMP_ADDR[0]) ##1 !bus_wr
		##1 (bus_rd && bus_addr == SEC_CMP_ADDR[0]) |=> bus_rdata == $past(bus_wdata, 3))
		else $error("secondary readback wrong");
	mode_readback_a: assert property ((bus_wr && bus_addr == MODE_ADDR[0] && !m0_q[RUN_BIT])
		##1 !bus_wr ##1 (bus_rd && bus_addr == MODE_ADDR[0]) |=> bus_rdata == $past(bus_wdata, 3))
		else $error("mode readback wrong");
	irq_toggle_a: assert property (match_irq[0] && m0_q[GATE_BIT] && m0_q[RUN_BIT] |->
		timer_out_pin[0] != $past(timer_out_pin[0])) else $error("match without toggle");
	irq_run_a: assert property (match_irq[0] |-> $past(m0_q[RUN_BIT]))
		else $error("match while stopped");
	stop_level_a: assert property ((!m0_q[RUN_BIT] && $stable(m0_q)) [*3] |->
		timer_out_pin[0] == m0_q[LEVEL_BIT]) else $error("stopped pin not at level");
	cover property (match_irq[0]);
	cover property (match_irq[1]);
	cover property (match_irq[2]);
endmodule : cmp_timer_chk

bind cmp_timer cmp_timer_chk u_chk (.clk, .rst_n, .bus_addr, .bus_wdata, .bus_wr, .bus_rd,
	.bus_rdata, .match_irq, .timer_out_pin, .carrier_out);

// File: testbench/irq_sink.sv
// interrupt controller model: tallies match pulses per instance
// assumes one-cycle pulses on clk; pins are judged by the checker
module irq_sink
	import cmp_timer_pkg::*;
(
	// clock and reset
	input	wire logic			clk,
	input	wire logic			rst_n,
	// pulses in, tallies out
	input	wire logic [NUM_INST-1:0]	match_irq,
	output	int				irq_cnt [NUM_INST]
);
	always @(posedge clk or negedge rst_n)
		for (int i = 0; i < NUM_INST; i++)
			irq_cnt[i] <= !rst_n ? 0 : irq_cnt[i] + int'(match_irq[i]);
endmodule : irq_sink

// File: testbench/tb.sv
// bench for cmp_timer: register readback, match tallies, refused writes
// assumes the checker binds itself to cmp_timer
module tb
	import cmp_timer_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic			clk = 1'b0;
	logic			rst_n = 1'b0;
	logic [15:0]		bus_addr = '0;
	logic [7:0]		bus_wdata = '0;
	logic			bus_wr = 1'b0;
	logic			bus_rd = 1'b0;
	logic			rd_p = 1'b0;
	logic [7:0]		bus_rdata;
	logic [NUM_INST-1:0]	match_irq;
	logic [NUM_PINS-1:0]	timer_out_pin;
	logic			carrier_out;
	logic [7:0]		r;
	logic [7:0]		exp_q [$];
	int			irq_cnt [NUM_INST];
	int			n_mismatch = 0;
	int			total_checks = 0;
	int			cycles = 0;
	int			seed = 34;
	int			n, p, b, k;
	int			inst_t [6] = '{0, 1, 1, 2, 0, 2};
	logic [7:0]		mode_t [6] = '{8'h81, 8'h89, 8'h85, 8'h81, 8'h85, 8'h89};
	cmp_timer dut (.clk, .rst_n, .bus_addr, .bus_wdata, .bus_wr, .bus_rd, .bus_rdata,
		.match_irq, .timer_out_pin, .carrier_out);
	irq_sink sink (.clk, .rst_n, .match_irq, .irq_cnt);
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(negedge clk);
		bus_addr = a;
		bus_wdata = d;
		bus_wr = 1'b1;
		@(negedge clk);
		bus_wr = 1'b0;
	endtask : wr
	task automatic rd(input logic [15:0] a, input logic [7:0] e);
		@(negedge clk);
		bus_addr = a;
		bus_rd = 1'b1;
		exp_q.push_back(e);
		@(negedge clk);
		bus_rd = 1'b0;
	endtask : rd
	task automatic chk8(input logic [7:0] g, input logic [7:0] e);
		total_checks++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("CHECK FAILED %0t read %h want %h", $time, g, e);
		end
	endtask : chk8
	task automatic chk_n(input int g, input int e);
		total_checks++;
		if (g != e)
		begin
			n_mismatch++;
			$display("CHECK FAILED %0t pulses %0d want %0d", $time, g, e);
		end
	endtask : chk_n
	task automatic close_out();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : close_out
	initial
	begin
		forever #5 clk = ~clk;
	end
	// read data lands one cycle after the strobe edge
	always @(posedge clk)
	begin
		cycles++;
		if (rd_p)
			chk8(bus_rdata, exp_q.pop_front());
		rd_p <= bus_rd;
		if (cycles == 5000)
		begin
			n_mismatch++;
			close_out();
		end
	end
	initial
	begin
		repeat (6) @(negedge clk);
		rst_n = 1'b1;
		rd(16'h0000, 8'h00);
		for (int i = 0; i < NUM_INST; i++)
		begin
			r = 8'($random(seed));
			rd(SEC_CMP_ADDR[i], CMP_RESET);
			rd(PRI_CMP_ADDR[i], CMP_RESET);
			wr(SEC_CMP_ADDR[i], r);
			rd(SEC_CMP_ADDR[i], r);
			wr(PRI_CMP_ADDR[i], ~r);
			rd(PRI_CMP_ADDR[i], ~r);
		end
		wr(CARRIER_ADDR, 8'h01);
		rd(CARRIER_ADDR, 8'h01);
		$display("test 0 done");
		// period: secondary clears first in carrier mode, else primary
		for (int t = 0; t < 6; t++)
		begin
			k = inst_t[t];
			n = 6 + ($random(seed) & 7);
			p = (k == CARRIER_INST && mode_t[t] == 8'h85) ? n - 2 : n + 1;
			b = irq_cnt[k];
			wr(SEC_CMP_ADDR[k], 8'(n - 3));
			wr(PRI_CMP_ADDR[k], 8'(n));
			wr(MODE_ADDR[k], mode_t[t]);
			wr(PRI_CMP_ADDR[k], 8'h01);
			repeat (4 * p + p / 2) @(negedge clk);
			chk_n(irq_cnt[k] - b, 4);
			rd(PRI_CMP_ADDR[k], 8'(n));
			wr(MODE_ADDR[k], MODE_RESET);
			// a running mode write moves only the run bit, so the other fields stay
			rd(MODE_ADDR[k], mode_t[t] & 8'h7F);
			b = irq_cnt[k];
			repeat (3 * p) @(negedge clk);
			chk_n(irq_cnt[k] - b, 0);
			$display("test %0d done", t + 1);
		end
		close_out();
	end
endmodule : tb
